/* hw/scpt_pkg.sv */
// constants shared by the sync, phase, compensation and telemetry logic
// assumes a single 40 MHz core clock; counts below are in those cycles unless named in ns or periods
package scpt_pkg;

	// core clock and sync pulse timing
	localparam int unsigned SCPT_CLK_HZ         = 40_000_000;
	localparam int unsigned SCPT_SYNC_PULSE_NS  = 500;
	localparam int unsigned SCPT_SYNC_PULSE_CYC =
		(SCPT_SYNC_PULSE_NS * (SCPT_CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned SCPT_EXT_LOSS_PERIODS = 2;

	// command codes of the serial management port
	localparam logic [7:0] SCPT_CMD_GCFG     = 8'h01;
	localparam logic [7:0] SCPT_CMD_PADS     = 8'h02;
	localparam logic [7:0] SCPT_CMD_PHASE    = 8'h03;
	localparam logic [7:0] SCPT_CMD_FREQ     = 8'h04;
	localparam logic [7:0] SCPT_CMD_COMP     = 8'h05;
	localparam logic [7:0] SCPT_CMD_MODE     = 8'h06;
	localparam logic [7:0] SCPT_CMD_CAL_GAIN = 8'h07;
	localparam logic [7:0] SCPT_CMD_IOUT     = 8'h08;
	localparam logic [7:0] SCPT_CMD_TEMP1    = 8'h09;
	localparam logic [7:0] SCPT_CMD_TEMP2    = 8'h0a;

	// field positions
	localparam int unsigned SCPT_GCFG_MASTER_BIT  = 0;
	localparam int unsigned SCPT_GCFG_EXT_REQ_BIT = 4;
	localparam int unsigned SCPT_PADS_EXT_BIT     = 0;
	localparam int unsigned SCPT_PADS_SWEN_BIT    = 1;
	localparam int unsigned SCPT_PADS_SYNC_BIT    = 10;
	localparam int unsigned SCPT_PH_CH0_LSB       = 0;
	localparam int unsigned SCPT_PH_CH1_LSB       = 3;
	localparam int unsigned SCPT_PH_FOLLOW_BIT    = 7;
	localparam int unsigned SCPT_COMP_RES_LSB     = 0;
	localparam int unsigned SCPT_COMP_GM_LSB      = 5;
	localparam int unsigned SCPT_MODE_DIRECT_BIT  = 0;

	// values after reset
	localparam logic [15:0] SCPT_GCFG_RST   = 16'h0001;
	localparam logic [7:0]  SCPT_PHASE_RST  = 8'h20;
	localparam logic [15:0] SCPT_PERIOD_RST = 16'h00a0;
	localparam logic [7:0]  SCPT_COMP_RST   = 8'h00;
	localparam logic [7:0]  SCPT_MODE_RST   = 8'h00;
	localparam logic [15:0] SCPT_GAIN_RST   = 16'h0100;

	// temperature conversion scale and offset, fixed point
	localparam logic [15:0] SCPT_TEMP_SCALE  = 16'h0040;
	localparam logic [15:0] SCPT_TEMP_OFS    = 16'h0111;
	localparam logic [15:0] SCPT_VBE_AT_ZERO = 16'h2c00;

	// telemetry adc selections
	typedef enum logic [2:0] {
		SCPT_ADC_IOUT, SCPT_ADC_EXT_LO, SCPT_ADC_EXT_HI, SCPT_ADC_INT_LO, SCPT_ADC_INT_HI
	} scpt_adc_sel_t;

endpackage

/* hw/scpt_telem_if.sv */
// carrier between the control top and the telemetry sequencer
// both sides run on the same core clock
`timescale 1ns/100ps
`default_nettype none
interface scpt_telem_if;
	logic [15:0] cal_gain;
	logic        direct_mode;
	logic        adc_start;
	logic [2:0]  adc_sel;
	logic        ext_bias_hi;
	logic [15:0] adc_data;
	logic        adc_done;
	logic [15:0] iout;
	logic [15:0] temp_ext;
	logic [15:0] temp_int;
	modport ctrl  (output cal_gain, direct_mode, adc_data, adc_done,
		input adc_start, adc_sel, ext_bias_hi, iout, temp_ext, temp_int);
	modport telem (input cal_gain, direct_mode, adc_data, adc_done,
		output adc_start, adc_sel, ext_bias_hi, iout, temp_ext, temp_int);
endinterface
`default_nettype wire

/* hw/scpt_phase_gen.sv */
// delays the reference tick by code/8 of the switching period
// assumes ref_tick_i is a one-cycle pulse at most once per period
`timescale 1ns/100ps
`default_nettype none
module scpt_phase_gen #(
	parameter int unsigned PW = 16
) (
	input  wire logic          clk_i,
	input  wire logic          rst_n_i,
	input  wire logic          ref_tick_i,
	input  wire logic [PW-1:0] period_i,
	input  wire logic [2:0]    code_i,
	output logic               set_o
);
	logic [PW+2:0] prod;
	logic [PW-1:0] dly_reg;
	logic          armed_reg;

	assign prod = {3'h0, period_i} * {{PW{1'b0}}, code_i};

	// load the delay on each tick, fire the latch-set edge when it runs out
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dly_reg   <= '0;
			armed_reg <= 1'b0;
			set_o     <= 1'b0;
		end else if (ref_tick_i) begin
			dly_reg   <= prod[PW+2:3];
			armed_reg <= 1'b1;
			set_o     <= 1'b0;
		end else if (armed_reg && dly_reg == '0) begin
			armed_reg <= 1'b0;
			set_o     <= 1'b1;
		end else begin
			dly_reg <= (dly_reg == '0) ? dly_reg : dly_reg - 1'b1;
			set_o   <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* hw/scpt_telem.sv */
// sequences the telemetry adc: output current, remote and on-chip diode
// assumes the adc answers each start with one done pulse, same clock
`timescale 1ns/100ps
`default_nettype none
module scpt_telem
	import scpt_pkg::*;
(
	input  wire logic   clk_i,
	input  wire logic   rst_n_i,
	scpt_telem_if.telem tif
);
	scpt_adc_sel_t sel_reg;
	logic          wait_reg;
	logic [15:0]   lo_reg;
	logic [31:0]   iprod;
	logic [31:0]   tprod;

	assign iprod = tif.adc_data * tif.cal_gain;
	assign tprod = (tif.adc_data - lo_reg) * SCPT_TEMP_SCALE;

	// round robin of conversions; for each diode the low current comes before the high
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sel_reg         <= SCPT_ADC_IOUT;
			wait_reg        <= 1'b0;
			lo_reg          <= '0;
			tif.adc_start   <= 1'b0;
			tif.adc_sel     <= 3'h0;
			tif.ext_bias_hi <= 1'b0;
			tif.iout        <= '0;
			tif.temp_ext    <= '0;
			tif.temp_int    <= '0;
		end else if (!wait_reg) begin
			tif.adc_start   <= 1'b1;
			tif.adc_sel     <= sel_reg;
			tif.ext_bias_hi <= (sel_reg == SCPT_ADC_EXT_HI); // 32 uA else 2 uA
			wait_reg        <= 1'b1;
		end else begin
			tif.adc_start <= 1'b0;
			if (tif.adc_done) begin
				wait_reg <= 1'b0;
				case (sel_reg)
					SCPT_ADC_IOUT: begin
						tif.iout <= iprod[23:8]; // sense volts times calibration
						sel_reg  <= SCPT_ADC_EXT_LO;
					end
					SCPT_ADC_EXT_LO: begin
						lo_reg  <= tif.adc_data;
						sel_reg <= SCPT_ADC_EXT_HI;
						if (tif.direct_mode) begin
							tif.temp_ext <= SCPT_VBE_AT_ZERO - tif.adc_data; // direct vbe
						end
					end
					SCPT_ADC_EXT_HI: begin
						sel_reg <= SCPT_ADC_INT_LO;
						if (!tif.direct_mode) begin
							tif.temp_ext <= tprod[23:8] - SCPT_TEMP_OFS; // delta vbe
						end
					end
					SCPT_ADC_INT_LO: begin
						lo_reg  <= tif.adc_data;
						sel_reg <= SCPT_ADC_INT_HI;
					end
					SCPT_ADC_INT_HI: begin
						tif.temp_int <= tprod[23:8] - SCPT_TEMP_OFS; // on-chip delta vbe
						sel_reg      <= SCPT_ADC_IOUT;
					end
					default: sel_reg <= SCPT_ADC_IOUT;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* hw/scpt_top.sv */
// switching clock sync, phase placement, loop compensation and telemetry
// assumes a 40 MHz core clock; sync and the input-sense comparator are async pins
`timescale 1ns/100ps
`default_nettype none
module scpt_top
	import scpt_pkg::*;
#(
	parameter int unsigned PERIOD_W = 16
) (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        cmd_valid_i,
	input  wire logic        cmd_write_i,
	input  wire logic [7:0]  cmd_code_i,
	input  wire logic [15:0] cmd_wdata_i,
	output logic             rsp_valid_o,
	output logic [15:0]      rsp_data_o,
	output logic             rsp_refused_o,
	input  wire logic [1:0]  chan_on_i,
	input  wire logic        isense_low_i,
	input  wire logic        sync_i,
	output logic             sync_o,
	output logic             sync_oe_o,
	output logic [1:0]       pwm_set_o,
	output logic             switch_en_o,
	output logic             ch1_follow_o,
	output logic [4:0]       comp_res_o,
	output logic [2:0]       comp_gm_o,
	output logic             adc_start_o,
	output logic [2:0]       adc_sel_o,
	input  wire logic [15:0] adc_data_i,
	input  wire logic        adc_done_i,
	output logic             ext_bias_hi_o
);
	localparam int unsigned PULSE_LAST = SCPT_SYNC_PULSE_CYC - 1;

	// refuse widths the period arithmetic cannot carry
	if (PERIOD_W < 8 || PERIOD_W > 16) begin : g_bad_width
		$error("scpt_top: PERIOD_W must lie between 8 and 16");
	end

	// command codes that may only change while both channels are off
	function automatic logic guarded_cmd(input logic [7:0] code);
		guarded_cmd = (code == SCPT_CMD_FREQ) || (code == SCPT_CMD_PHASE);
	endfunction

	logic                sync_s1_reg;
	logic                sync_s2_reg;
	logic                sync_d3_reg;
	logic                isl_s1_reg;
	logic                isl_s2_reg;
	logic [15:0]         gcfg_reg;
	logic [7:0]          phase_reg;
	logic [PERIOD_W-1:0] period_reg;
	logic [7:0]          comp_reg;
	logic [7:0]          mode_reg;
	logic [15:0]         gain_reg;
	logic [PERIOD_W-1:0] osc_cnt_reg;
	logic [7:0]          pulse_cnt_reg;
	logic                sync_oe_reg;
	logic                drive_en_reg;
	logic                ext_present_reg;
	logic [PERIOD_W:0]   lost_cnt_reg;
	logic                switch_en_reg;
	logic                switch_en_next;
	logic [1:0]          set_raw;
	logic [1:0]          pwm_set_reg;
	logic [15:0]         rd_mux;
	logic                wr_take;
	logic                wr_refuse;
	logic                osc_wrap;
	logic                sync_fall;
	logic                ext_edge;
	logic                line_busy;
	logic                ref_tick;
	logic                is_master;
	logic                ext_required;

	scpt_telem_if tif ();

	// two-stage synchronisers; the second stage feeds logic, and sync also through its one-cycle delayed copy
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync_s1_reg <= 1'b1;
			sync_s2_reg <= 1'b1;
			sync_d3_reg <= 1'b1;
			isl_s1_reg  <= 1'b0;
			isl_s2_reg  <= 1'b0;
		end else begin
			sync_s1_reg <= sync_i;
			sync_s2_reg <= sync_s1_reg;
			sync_d3_reg <= sync_s2_reg;
			isl_s1_reg  <= isense_low_i;
			isl_s2_reg  <= isl_s1_reg;
		end
	end

	assign is_master    = gcfg_reg[SCPT_GCFG_MASTER_BIT];
	assign ext_required = gcfg_reg[SCPT_GCFG_EXT_REQ_BIT];
	assign sync_fall    = sync_d3_reg && !sync_s2_reg;
	// our own pull shows up a few cycles late, so edges during our pulse are ours
	assign ext_edge     = sync_fall && !sync_oe_reg;
	// line already low when we would start: another master owns it
	assign line_busy    = !sync_s2_reg && !sync_oe_reg;
	assign osc_wrap     = (osc_cnt_reg >= period_reg - 1'b1); // a shortened period never overruns
	assign ref_tick     = ext_present_reg ? ext_edge : osc_wrap;

	// command decode
	assign wr_take   = cmd_valid_i && cmd_write_i;
	assign wr_refuse = wr_take && guarded_cmd(cmd_code_i) && (|chan_on_i);

	// writable registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gcfg_reg   <= SCPT_GCFG_RST;
			phase_reg  <= SCPT_PHASE_RST;
			period_reg <= SCPT_PERIOD_RST[PERIOD_W-1:0];
			comp_reg   <= SCPT_COMP_RST;
			mode_reg   <= SCPT_MODE_RST;
			gain_reg   <= SCPT_GAIN_RST;
		end else if (wr_take && !wr_refuse) begin
			case (cmd_code_i)
				SCPT_CMD_GCFG:     gcfg_reg   <= cmd_wdata_i;
				SCPT_CMD_PHASE:    phase_reg  <= cmd_wdata_i[7:0];
				SCPT_CMD_FREQ:     period_reg <= cmd_wdata_i[PERIOD_W-1:0];
				SCPT_CMD_COMP:     comp_reg   <= cmd_wdata_i[7:0];
				SCPT_CMD_MODE:     mode_reg   <= cmd_wdata_i[7:0];
				SCPT_CMD_CAL_GAIN: gain_reg   <= cmd_wdata_i;
				default:           gain_reg   <= gain_reg;
			endcase
		end
	end

	// read mux; unknown codes read as zero
	always_comb begin
		rd_mux = 16'h0000;
		case (cmd_code_i)
			SCPT_CMD_GCFG:     rd_mux = gcfg_reg;
			SCPT_CMD_PADS: begin
				rd_mux[SCPT_PADS_SYNC_BIT] = sync_oe_reg;
				rd_mux[SCPT_PADS_EXT_BIT]  = ext_present_reg;
				rd_mux[SCPT_PADS_SWEN_BIT] = switch_en_reg;
			end
			SCPT_CMD_PHASE:    rd_mux = {8'h00, phase_reg};
			SCPT_CMD_FREQ:     rd_mux = 16'(period_reg);
			SCPT_CMD_COMP:     rd_mux = {8'h00, comp_reg};
			SCPT_CMD_MODE:     rd_mux = {8'h00, mode_reg};
			SCPT_CMD_CAL_GAIN: rd_mux = gain_reg;
			SCPT_CMD_IOUT:     rd_mux = tif.iout;
			SCPT_CMD_TEMP1:    rd_mux = tif.temp_ext;
			SCPT_CMD_TEMP2:    rd_mux = tif.temp_int;
			default:           rd_mux = 16'h0000;
		endcase
	end

	// one answer per command, one cycle later
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rsp_valid_o   <= 1'b0;
			rsp_data_o    <= 16'h0000;
			rsp_refused_o <= 1'b0;
		end else begin
			rsp_valid_o   <= cmd_valid_i;
			rsp_data_o    <= (cmd_valid_i && !cmd_write_i) ? rd_mux : 16'h0000;
			rsp_refused_o <= wr_refuse;
		end
	end

	// internal oscillator, re-phased on every external edge so a loss is seamless
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			osc_cnt_reg <= '0;
		end else if (ext_edge || osc_wrap) begin
			osc_cnt_reg <= '0;
		end else begin
			osc_cnt_reg <= osc_cnt_reg + 1'b1;
		end
	end

	// external clock presence; lost after two nominal periods without an edge
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ext_present_reg <= 1'b0;
			lost_cnt_reg    <= '0;
		end else if (ext_edge) begin
			ext_present_reg <= 1'b1;
			lost_cnt_reg    <= '0;
		end else if (ext_present_reg) begin
			if (lost_cnt_reg >= (PERIOD_W+1)'(SCPT_EXT_LOSS_PERIODS) * {1'b0, period_reg}) begin
				ext_present_reg <= 1'b0;
			end
			lost_cnt_reg <= lost_cnt_reg + 1'b1;
		end
	end

	// yield the line for good once anyone else is seen on it; a config write re-arms
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			drive_en_reg <= 1'b1;
		end else if (ext_edge || (osc_wrap && line_busy)) begin
			drive_en_reg <= 1'b0;
		end else if (wr_take && cmd_code_i == SCPT_CMD_GCFG) begin
			drive_en_reg <= 1'b1;
		end
	end

	// master pulse: low for a fixed width at each oscillator wrap while master, drive is enabled, no external clock is present and the line is free
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync_oe_reg   <= 1'b0;
			pulse_cnt_reg <= 8'h00;
		end else if (sync_oe_reg) begin
			if (pulse_cnt_reg == 8'(PULSE_LAST)) begin
				sync_oe_reg <= 1'b0;
			end
			pulse_cnt_reg <= pulse_cnt_reg + 8'h01;
		end else if (osc_wrap && is_master && drive_en_reg && !ext_present_reg
			&& !line_busy) begin
			sync_oe_reg   <= 1'b1;
			pulse_cnt_reg <= 8'h00;
		end
	end

	// open drain: only ever pulls low
	assign sync_o    = 1'b0;
	assign sync_oe_o = sync_oe_reg;

	// switching permission
	assign switch_en_next = !isl_s2_reg && !(ext_required && !ext_present_reg);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			switch_en_reg <= 1'b0;
		end else begin
			switch_en_reg <= switch_en_next;
		end
	end

	// one phase generator per channel
	for (genvar ch = 0; ch < 2; ch++) begin : g_phase
		scpt_phase_gen #(
			.PW(PERIOD_W)
		) u_phase (
			.clk_i      (clk_i),
			.rst_n_i    (rst_n_i),
			.ref_tick_i (ref_tick),
			.period_i   (period_reg),
			.code_i     (phase_reg[3*ch +: 3]),
			.set_o      (set_raw[ch])
		);
	end

	// gate the latch-set edges; the analog side also sees switch_en
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pwm_set_reg <= 2'h0;
		end else begin
			pwm_set_reg <= set_raw & chan_on_i & {2{switch_en_reg}};
		end
	end

	// static configuration outputs, registered once more
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ch1_follow_o <= 1'b0;
			comp_res_o   <= 5'h00;
			comp_gm_o    <= 3'h0;
		end else begin
			ch1_follow_o <= phase_reg[SCPT_PH_FOLLOW_BIT];
			comp_res_o   <= comp_reg[SCPT_COMP_RES_LSB +: 5];
			comp_gm_o    <= comp_reg[SCPT_COMP_GM_LSB +: 3];
		end
	end

	assign pwm_set_o   = pwm_set_reg;
	assign switch_en_o = switch_en_reg;

	// telemetry sequencer
	assign tif.cal_gain    = gain_reg;
	assign tif.direct_mode = mode_reg[SCPT_MODE_DIRECT_BIT];
	assign tif.adc_data    = adc_data_i;
	assign tif.adc_done    = adc_done_i;
	assign adc_start_o     = tif.adc_start;
	assign adc_sel_o       = tif.adc_sel;
	assign ext_bias_hi_o   = tif.ext_bias_hi;

	scpt_telem u_telem (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.tif     (tif)
	);

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sync_pulse_width_a: assert property ($fell(sync_oe_reg) |-> $past(pulse_cnt_reg) == 8'(PULSE_LAST))
		else $error("sync pulse width wrong");
	sync_pulse_start_a: assert property ($rose(sync_oe_reg) |-> $past(osc_wrap) && $past(is_master))
		else $error("sync pulse not on oscillator wrap");
	ext_yield_drive_a: assert property (ext_edge |=> !drive_en_reg ##1 !$rose(sync_oe_reg))
		else $error("sync drive kept after external edge");
	ext_lock_tick_a: assert property (ext_present_reg && ext_edge |=> osc_cnt_reg == '0)
		else $error("oscillator not re-phased to external edge");
	fallback_run_a: assert property (!isl_s2_reg && !ext_required |=> switch_en_reg)
		else $error("internal fallback did not keep switching");
	ext_required_a: assert property (ext_required && !ext_present_reg |=> !switch_en_reg)
		else $error("switching without required external clock");
	isense_stop_a: assert property (isl_s2_reg |=> !switch_en_reg ##1 pwm_set_reg == 2'h0)
		else $error("switching with low input sense");
	pads_sync_bit_a: assert property (cmd_valid_i && !cmd_write_i && cmd_code_i == SCPT_CMD_PADS
		|=> rsp_data_o[SCPT_PADS_SYNC_BIT] == $past(sync_oe_reg))
		else $error("pad status sync bit wrong");
	guarded_write_a: assert property (wr_refuse |=> $stable(period_reg) && $stable(phase_reg)
		&& rsp_refused_o)
		else $error("guarded write not ignored");
	comp_fields_a: assert property (wr_take && cmd_code_i == SCPT_CMD_COMP |-> ##2
		comp_res_o == $past(cmd_wdata_i[4:0], 2) && comp_gm_o == $past(cmd_wdata_i[7:5], 2))
		else $error("compensation fields not applied");
	follow_bit_a: assert property (wr_take && !wr_refuse && cmd_code_i == SCPT_CMD_PHASE |-> ##2
		ch1_follow_o == $past(cmd_wdata_i[7], 2))
		else $error("follow bit not applied");

	master_pulse_c: cover property ($rose(sync_oe_reg));
	ext_lock_c: cover property (ext_edge ##1 ext_present_reg);
	refused_write_c: cover property (wr_refuse);
	ext_lost_c: cover property ($fell(ext_present_reg));
endmodule
`default_nettype wire

/* tb/scpt_sync_peer.sv */
// another clock master sharing the open-drain sync line
// assumes the bench forms the line level with a pull-up from all pulls
`timescale 1ns/100ps
`default_nettype none
module scpt_sync_peer (
	input  wire logic en_i,
	output logic      pull_o
);
	// 200 ns link period with 100 ns low pulses; stands still while disabled
	initial begin
		pull_o = 1'b0;
		#7;
		forever begin
			wait (en_i);
			pull_o = 1'b1;
			#100 pull_o = 1'b0;
			#100;
		end
	end
endmodule
`default_nettype wire

/* tb/sync_phase_config_telemetry_tb.sv */
// self-checking bench: command port, sync line with a peer master, phase, telemetry
// assumes a 40 MHz core clock and a pulled-up wired sync line
`timescale 1ns/100ps
`default_nettype none
module sync_phase_config_telemetry_tb;
	import scpt_pkg::*;
	logic        clk_i = 1'b0, rst_n_i = 1'b0, cmd_valid_i = 1'b0, cmd_write_i = 1'b0;
	logic [7:0]  cmd_code_i = 8'h00;
	logic [15:0] cmd_wdata_i = 16'h0000, adc_data_i = 16'h0000, rsp_data_o, rd;
	logic        rsp_valid_o, rsp_refused_o, sync_o, sync_oe_o, switch_en_o, ch1_follow_o;
	logic        adc_start_o, ext_bias_hi_o, adc_done_i = 1'b0, isense_low_i = 1'b0;
	logic        peer_en = 1'b0, peer_pull;
	logic [1:0]  chan_on_i = 2'b00, pwm_set_o;
	logic [4:0]  comp_res_o;
	logic [2:0]  comp_gm_o, adc_sel_o, asel;
	logic [15:0] adc_val [5] = '{16'h1234, 16'h1000, 16'h9000, 16'h2000, 16'h6000};
	int          err_total = 0, n_tests = 0, n;
	// wired line: low while any party pulls
	wire logic   sync_i = !(sync_oe_o || peer_pull);

	always #12.5 clk_i = ~clk_i;

	scpt_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
		.cmd_write_i(cmd_write_i), .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i),
		.rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_refused_o(rsp_refused_o),
		.chan_on_i(chan_on_i), .isense_low_i(isense_low_i), .sync_i(sync_i), .sync_o(sync_o),
		.sync_oe_o(sync_oe_o), .pwm_set_o(pwm_set_o), .switch_en_o(switch_en_o),
		.ch1_follow_o(ch1_follow_o), .comp_res_o(comp_res_o), .comp_gm_o(comp_gm_o),
		.adc_start_o(adc_start_o), .adc_sel_o(adc_sel_o), .adc_data_i(adc_data_i),
		.adc_done_i(adc_done_i), .ext_bias_hi_o(ext_bias_hi_o));
	scpt_sync_peer u_peer (.en_i(peer_en), .pull_o(peer_pull));

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		chk_word({15'h0000, got}, {15'h0000, exp});
	endtask

	// telemetry converter: answers each start three cycles later
	always @(negedge clk_i) if (adc_start_o) begin
		asel = adc_sel_o;
		repeat (2) @(negedge clk_i);
		chk_flag(ext_bias_hi_o, asel == 3'h2);
		@(negedge clk_i);
		adc_data_i = adc_val[asel];
		adc_done_i = 1'b1;
		@(negedge clk_i);
		adc_done_i = 1'b0;
	end

	// one command, answer taken the cycle after
	task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] wd);
		@(negedge clk_i);
		{cmd_valid_i, cmd_write_i, cmd_code_i, cmd_wdata_i} = {1'b1, wr, code, wd};
		@(negedge clk_i);
		cmd_valid_i = 1'b0;
		chk_flag(rsp_valid_o, 1'b1);
		rd = rsp_data_o;
	endtask
	task automatic wait_oe(input logic lvl);
		n = 0;
		while (sync_oe_o !== lvl && n < 400) begin
			@(negedge clk_i);
			n++;
		end
	endtask

	task automatic t_comp;
		cmd(1'b1, SCPT_CMD_COMP, 16'h00e3);
		@(negedge clk_i);
		chk_word(16'(comp_res_o), 16'h0003);
		chk_word(16'(comp_gm_o), 16'h0007);
		$display("t_comp done");
	endtask
	task automatic t_guard;
		chan_on_i = 2'b01;
		cmd(1'b1, SCPT_CMD_PHASE, 16'h0080);
		chk_flag(rsp_refused_o, 1'b1);
		chan_on_i = 2'b10;
		cmd(1'b1, SCPT_CMD_FREQ, 16'h0020);
		chk_flag(rsp_refused_o, 1'b1);
		cmd(1'b0, SCPT_CMD_PHASE, 16'h0000);
		chk_word(rd, 16'h0020);
		chan_on_i = 2'b00;
		cmd(1'b1, SCPT_CMD_FREQ, 16'h0020);
		cmd(1'b1, SCPT_CMD_PHASE, 16'h0080); // outputs assumed tied here
		chk_flag(rsp_refused_o, 1'b0);
		@(negedge clk_i);
		chk_flag(ch1_follow_o, 1'b1);
		$display("t_guard done");
	endtask
	task automatic t_master;
		wait_oe(1'b1);
		chk_flag(sync_o, 1'b0);
		wait_oe(1'b0);
		chk_word(16'(n), 16'h0014);
		wait_oe(1'b1);
		chk_word(16'(n), 16'h000c);
		cmd(1'b0, SCPT_CMD_PADS, 16'h0000);
		chk_flag(rd[10], 1'b1);
		$display("t_master done");
	endtask
	// ch1 at the reference, ch0 four eighths of 32 cycles later: two phases, 180 degrees
	task automatic t_phase;
		cmd(1'b1, SCPT_CMD_PHASE, 16'h0004);
		chan_on_i = 2'b11;
		n = 0;
		while (pwm_set_o[1] !== 1'b1 && n < 200) begin
			@(negedge clk_i);
			n++;
		end
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (pwm_set_o[0] !== 1'b1 && n < 100);
		chk_word(16'(n), 16'h0010);
		chan_on_i = 2'b00;
		$display("t_phase done");
	endtask
	task automatic t_isense;
		// input-off threshold kept below 2.5 V, so only the sense pin stops us
		isense_low_i = 1'b1;
		repeat (6) @(negedge clk_i);
		chk_flag(switch_en_o, 1'b0);
		isense_low_i = 1'b0;
		repeat (6) @(negedge clk_i);
		chk_flag(switch_en_o, 1'b1);
		$display("t_isense done");
	endtask
	task automatic t_telem;
		cmd(1'b0, SCPT_CMD_IOUT, 16'h0000);
		chk_word(rd, 16'h1234);
		cmd(1'b0, SCPT_CMD_TEMP1, 16'h0000);
		chk_word(rd, 16'h1eef);
		cmd(1'b0, SCPT_CMD_TEMP2, 16'h0000);
		chk_word(rd, 16'h0eef);
		cmd(1'b1, SCPT_CMD_MODE, 16'h0001);
		cmd(1'b1, SCPT_CMD_CAL_GAIN, 16'h0200);
		repeat (60) @(negedge clk_i);
		cmd(1'b0, SCPT_CMD_TEMP1, 16'h0000);
		chk_word(rd, 16'h1c00);
		cmd(1'b0, SCPT_CMD_IOUT, 16'h0000);
		chk_word(rd, 16'h2468);
		$display("t_telem done");
	endtask
	task automatic t_ext;
		peer_en = 1'b1;
		repeat (80) @(negedge clk_i);
		n = 0;
		repeat (100) begin
			@(negedge clk_i);
			n += int'(sync_oe_o === 1'b1);
		end
		chk_word(16'(n), 16'h0000);
		cmd(1'b0, SCPT_CMD_PADS, 16'h0000);
		chk_flag(rd[0], 1'b1);
		chk_flag(rd[10], 1'b0);
		peer_en = 1'b0;
		repeat (120) @(negedge clk_i);
		chk_flag(switch_en_o, 1'b1);
		cmd(1'b0, SCPT_CMD_PADS, 16'h0000);
		chk_flag(rd[0], 1'b0);
		cmd(1'b1, SCPT_CMD_GCFG, 16'h0010);
		repeat (4) @(negedge clk_i);
		chk_flag(switch_en_o, 1'b0);
		peer_en = 1'b1;
		repeat (40) @(negedge clk_i);
		chk_flag(switch_en_o, 1'b1);
		$display("t_ext done");
	endtask

	task automatic end_of_test;
		$display("%0d checks, %0d mismatches", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// run well under 2000 cycles; the limit leaves a wide margin
	initial begin
		#300000;
		err_total++;
		end_of_test;
	end
	initial begin
		repeat (20) @(negedge clk_i);
		rst_n_i = 1'b1;
		t_comp;
		t_guard;
		t_master;
		t_phase;
		t_isense;
		t_telem;
		t_ext;
		end_of_test;
	end
endmodule
`default_nettype wire
